// *** testbench/ectcs_core_monitor.sv ***
// ectcs_mon: port-level assertions for the command interpreter
`timescale 1ns/1ps
module ectcs_mon
    import ectcs_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        req_valid_i,
    input wire ectcs_req_t  req_i,
    input wire logic [2:0]  screen_sel_o,
    input wire logic        ack_o,
    input wire logic        reject_o,
    input wire logic [10:0] res_upper_o,
    input wire logic        volt_mode_o,
    input wire logic        testing_o,
    input wire logic        overload_o,
    input wire logic        limit_order_warn_o,
    input wire logic        overvoltage_setting_flag_o,
    input wire logic        over_resistance_flag_o,
    input wire logic        over_rating_flag_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // ======================================================================
    // request and blocking-flag shapes
    sequence s_req(c);
        req_valid_i && req_i.cmd == c;
    endsequence
    sequence s_blocked;
        limit_order_warn_o || overvoltage_setting_flag_o || over_resistance_flag_o
            || over_rating_flag_o;
    endsequence
    // ======================================================================
    // handshake, settings, test start and stop
    a_ack_follows: assert property (req_valid_i |=> ack_o) else $error("ack missing");
    a_reject_ack: assert property (reject_o |-> ack_o) else $error("reject without ack");
    a_res_mode: assert property (
        s_req(res_upper_ref_cmd) ##0 req_i.value inside {[1:600]} |=> !volt_mode_o)
        else $error("resistance write kept voltage mode");
    a_volt_mode: assert property (
        s_req(volt_upper_ref_cmd) ##0 req_i.value inside {[1:540]} |=> volt_mode_o)
        else $error("voltage write kept resistance mode");
    a_res_range: assert property (
        s_req(res_upper_ref_cmd) ##0 req_i.value > 1200 |=> reject_o && $stable(res_upper_o))
        else $error("out of range upper ref taken");
    a_start_screen: assert property (
        s_req(begin_test_cmd) ##0 !(screen_sel_o inside {0, 1, 4}) |=> reject_o)
        else $error("start accepted on wrong screen");
    a_flag_block: assert property (
        s_req(begin_test_cmd) ##0 s_blocked |=> reject_o && !testing_o)
        else $error("start accepted while blocked");
    a_stop_clear: assert property (
        s_req(ECTCS_CMD_STOP) |=> !testing_o && !overload_o)
        else $error("stop left test or overload");
endmodule

bind ectcs_core ectcs_mon u_mon (.clock_i, .rstn_i, .req_valid_i, .req_i, .screen_sel_o,
    .ack_o, .reject_o, .res_upper_o, .volt_mode_o, .testing_o, .overload_o,
    .limit_order_warn_o, .overvoltage_setting_flag_o, .over_resistance_flag_o,
    .over_rating_flag_o);

// *** testbench/ectcs_host.sv ***
// ectcs_host: remote host model issuing one command request at a time
`timescale 1ns/1ps
module ectcs_host
    import ectcs_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic ack_i,
    input  wire logic reject_i,
    output logic       req_valid_o,
    output ectcs_req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic send(input ectcs_cmd_t c, input logic [13:0] v, input logic f,
                        output logic rej, output logic ok);
        ok = 1'b0;
        rej = 1'b0;
        @(posedge clock_i);
        req_valid_o <= 1'b1;
        req_o <= '{cmd: c, value: v, flag: f};
        @(posedge clock_i);
        req_valid_o <= 1'b0;
        // idle lines must not look like the last request
        req_o.value <= ~v;
        // bounded wait for the answer
        repeat (3) begin
            #1;
            if (!ok && ack_i === 1'b1) begin
                ok = 1'b1;
                rej = reject_i;
            end
            if (!ok) @(posedge clock_i);
        end
    endtask
endmodule

// *** testbench/tb_ectcs_core.sv ***
// tb_ectcs_core: self-checking bench for the command interpreter
`timescale 1ns/1ps
module tb_ectcs_core
    import ectcs_pkg::*;
;
    typedef struct {ectcs_cmd_t c; logic [13:0] v; logic f; logic rej; logic [13:0] e;} ectcs_row_t;
    logic clock_i, rstn_i, req_valid_i, lower_judge_on_i, rating_exceeded_i, power_over_i;
    logic fail_i, prog_running_i, step_at_hold_i, r, ok;
    logic [10:0] res_lower_i, res_upper_o;
    logic [9:0] test_current_i, volt_upper_o;
    logic [2:0] screen_shown_i, screen_sel_o;
    logic [13:0] test_time_o, reply_o;
    logic [7:0] status_o;
    logic overvoltage_setting_flag_o, over_resistance_flag_o, reply_flag_o;
    logic ack_o, reject_o, volt_mode_o, offset_on_o, timer_on_o, testing_o, overload_o;
    logic limit_order_warn_o, over_rating_flag_o, mon_valid_o;
    ectcs_req_t req_i;
    ectcs_meas_t meas_i;
    ectcs_mon_t mon_o;
    int bad_count, checks_done;
    ectcs_row_t rows [10] = '{
        '{res_upper_ref_cmd, 14'h4b0, 1'b0, 1'b0, 14'h4b0},
        '{res_upper_ref_cmd, 14'h4b1, 1'b0, 1'b1, 14'h4b0},
        '{res_upper_ref_cmd, 14'h0, 1'b0, 1'b1, 14'h4b0},
        '{volt_upper_ref_cmd, 14'h21c, 1'b0, 1'b0, 14'h21c},
        '{volt_upper_ref_cmd, 14'h21d, 1'b0, 1'b1, 14'h21c},
        '{test_timer_cmd, 14'h3, 1'b1, 1'b0, 14'h3},
        '{test_timer_cmd, 14'h2, 1'b1, 1'b1, 14'h3},
        '{test_timer_cmd, 14'h2706, 1'b0, 1'b0, 14'h2706},
        '{ECTCS_CMD_SCREEN, 14'h4, 1'b0, 1'b0, 14'h4},
        '{ECTCS_CMD_SCREEN, 14'h5, 1'b0, 1'b1, 14'h4}};
    // short tick keeps the timer and blink counts within the run
    ectcs_core #(.TICK_CYC(10)) dut (.clock_i, .rstn_i, .req_valid_i, .req_i, .res_lower_i,
        .volt_lower_i(10'h1), .lower_judge_on_i, .test_current_i, .rating_exceeded_i,
        .power_over_i, .fail_i, .pass_i(1'b0), .pass_hold_i(1'b0), .prog_running_i,
        .step_at_hold_i, .meas_i, .screen_shown_i, .ack_o, .reject_o, .reply_o,
        .reply_flag_o, .mon_o, .mon_valid_o, .res_upper_o, .volt_upper_o, .volt_mode_o,
        .offset_on_o, .test_time_o, .timer_on_o, .screen_sel_o, .testing_o,
        .step_advance_o(), .limit_order_warn_o, .overvoltage_setting_flag_o,
        .over_resistance_flag_o, .over_rating_flag_o, .overload_o, .blink_o(),
        .status_o);
    ectcs_host host (.clock_i, .ack_i(ack_o), .reject_i(reject_o), .req_valid_o(req_valid_i),
        .req_o(req_i));
    // ======================================================================
    // clock, moving measurements, watchdog
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) meas_i.cur <= meas_i.cur + 10'h1;
    initial begin
        #400000;
        bad_count++;
        results();
    end
    function automatic logic [13:0] pick(ectcs_cmd_t c);
        case (c)
            res_upper_ref_cmd: return {3'h0, res_upper_o};
            volt_upper_ref_cmd: return {4'h0, volt_upper_o};
            test_timer_cmd: return test_time_o;
            default: return {11'h0, screen_sel_o};
        endcase
    endfunction
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {13'h0, e}, {13'h0, g});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic start(input logic e);
        host.send(begin_test_cmd, 14'h0, 1'b0, r, ok);
        chk1("start refused", e, r);
    endtask
    // ======================================================================
    // main sequence
    initial begin
        {rstn_i, lower_judge_on_i, rating_exceeded_i, power_over_i, fail_i} = '0;
        {prog_running_i, step_at_hold_i} = '0;
        {res_lower_i, screen_shown_i, meas_i} = '0;
        test_current_i = 10'h1e;
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            host.send(rows[i].c, rows[i].v, rows[i].f, r, ok);
            chk1("ack", 1'b1, ok);
            chk1("reject", rows[i].rej, r);
            chk("setting", rows[i].e, pick(rows[i].c));
        end
        $display("table rows done");
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk("default res", 14'h1, 14'(res_upper_o));
        chk("default volt", 14'h3c, 14'(volt_upper_o));
        chk("default time", 14'ha, test_time_o);
        chk("default bits", 14'h0, {offset_on_o, timer_on_o, volt_mode_o, screen_sel_o});
        host.send(res_upper_ref_cmd, 14'h5, 1'b0, r, ok);
        start(1'b0);
        chk1("testing", 1'b1, testing_o);
        host.send(monitor_query, 14'h0, 1'b0, r, ok);
        chk1("dsr testing bit", 1'b1, mon_o.dsr[ECTCS_DSR_TEST_BIT]);
        chk1("monitor mode", 1'b0, mon_o.volt_mode);
        chk("status", 14'hc, 14'(status_o));
        power_over_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        chk1("overload", 1'b1, overload_o);
        power_over_i <= 1'b0;
        host.send(ECTCS_CMD_STOP, 14'h0, 1'b0, r, ok);
        chk1("stopped", 1'b0, testing_o | overload_o);
        host.send(ECTCS_CMD_SCREEN, 14'(system_setup_screen), 1'b0, r, ok);
        start(1'b1);
        host.send(ECTCS_CMD_SCREEN, 14'(ECTCS_SCR_MAIN), 1'b0, r, ok);
        {lower_judge_on_i, res_lower_i} <= {1'b1, 11'ha};
        repeat (3) @(posedge clock_i);
        #1;
        chk1("limit order", 1'b1, limit_order_warn_o);
        start(1'b1);
        {lower_judge_on_i, rating_exceeded_i} <= 2'b01;
        repeat (3) @(posedge clock_i);
        #1;
        chk1("over rating", 1'b1, over_rating_flag_o);
        start(1'b1);
        {rating_exceeded_i, test_current_i} <= {1'b0, 10'h3c};
        host.send(res_upper_ref_cmd, 14'h3e8, 1'b0, r, ok);
        start(1'b1);
        chk1("over voltage", 1'b1, overvoltage_setting_flag_o);
        host.send(volt_upper_ref_cmd, 14'h12c, 1'b0, r, ok);
        repeat (2) @(posedge clock_i);
        #1;
        chk1("over resistance", 1'b0, over_resistance_flag_o);
        host.send(volt_upper_ref_cmd, 14'h21c, 1'b0, r, ok);
        start(1'b1);
        chk1("over resistance", 1'b1, over_resistance_flag_o);
        host.send(ECTCS_CMD_OFFSET, 14'h0, 1'b1, r, ok);
        screen_shown_i <= 3'h6;
        host.send(ECTCS_CMD_QUERY_SET, 14'h0, 1'b0, r, ok);
        chk("screen query", 14'(ECTCS_SCR_OTHER), reply_o);
        chk1("offset query", 1'b1, reply_flag_o);
        $display("hand tests done");
        results();
    end
endmodule

// *** verilog/ectcs_core.sv ***
// ectcs_core: command interpreter of the earth continuity tester
`timescale 1ns/1ps
module ectcs_core
    import ectcs_pkg::*;
#(
    parameter bit          BIG_VARIANT = 1'b1,
    parameter int unsigned TICK_CYC    = ECTCS_TICK_CYC
)(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        req_valid_i,
    input  wire ectcs_req_t  req_i,
    input  wire logic [10:0] res_lower_i,
    input  wire logic [9:0]  volt_lower_i,
    input  wire logic        lower_judge_on_i,
    input  wire logic [9:0]  test_current_i,
    input  wire logic        rating_exceeded_i,
    input  wire logic        power_over_i,
    input  wire logic        fail_i,
    input  wire logic        pass_i,
    input  wire logic        pass_hold_i,
    input  wire logic        prog_running_i,
    input  wire logic        step_at_hold_i,
    input  wire ectcs_meas_t meas_i,
    input  wire logic [2:0]  screen_shown_i,
    output logic             ack_o,
    output logic             reject_o,
    output logic [13:0]      reply_o,
    output logic             reply_flag_o,
    output ectcs_mon_t       mon_o,
    output logic             mon_valid_o,
    output logic [10:0]      res_upper_o,
    output logic [9:0]       volt_upper_o,
    output logic             volt_mode_o,
    output logic             offset_on_o,
    output logic [13:0]      test_time_o,
    output logic             timer_on_o,
    output logic [2:0]       screen_sel_o,
    output logic             testing_o,
    output logic             step_advance_o,
    output logic             limit_order_warn_o,
    output logic             overvoltage_setting_flag_o,
    output logic             over_resistance_flag_o,
    output logic             over_rating_flag_o,
    output logic             overload_o,
    output logic             blink_o,
    output logic [7:0]       status_o
);
    // ======================================================================
    // state
    typedef struct packed {
        logic [10:0]  res_up;
        logic [9:0]   volt_up;
        logic         volt_mode;
        logic         offset_on;
        logic [13:0]  ttime;
        logic         timer_on;
        logic [2:0]   screen;
        ectcs_state_t state;
        logic [13:0]  elapsed;
        logic [23:0]  tick_cnt;
        logic         ack;
        logic         reject;
        logic [13:0]  reply;
        logic         reply_flag;
        ectcs_mon_t   mon;
        logic         mon_valid;
        logic         step_adv;
        logic         warn;
        logic         ovolt;
        logic         ores;
        logic         orate;
        logic         oload;
        logic         blink;
        logic [23:0]  blink_cnt;
        logic         testing;
    } ectcs_st_t;

    ectcs_st_t   st_r;
    ectcs_st_t   st_nxt;
    ectcs_meas_t held;
    logic [10:0] res_max;
    logic [9:0]  volt_max;
    logic [10:0] res_lim;
    logic        block_start;
    logic [20:0] vi_prod;
    logic [23:0] v_scaled;
    logic [23:0] i_scaled;
    logic [13:0] remain;
    logic        live;

    // ======================================================================
    // helpers
    function automatic logic time_ok(input logic [13:0] t);
        // fine steps up to 99.9 s, whole seconds from 100 s
        time_ok = (t >= ECTCS_TIME_MIN) && (t <= ECTCS_TIME_MAX) &&
                  ((t <= ECTCS_TIME_FINE) || ((t % ECTCS_TIME_COARSE) == 14'h0));
    endfunction

    function automatic logic start_screen(input logic [2:0] s);
        start_screen = (s == ECTCS_SCR_MAIN) || (s == ECTCS_SCR_OFFSET) ||
                       (s == ECTCS_SCR_PROG);
    endfunction

    assign live = (st_r.state == ECTCS_ST_TEST);

    ectcs_hold u_hold (
        .clock_i    (clock_i),
        .rstn_i     (rstn_i),
        .live_i     (live),
        .meas_i     (meas_i),
        .held_o     (held),
        .res_max_o  (res_max),
        .volt_max_o (volt_max)
    );

    // ======================================================================
    // setting checks, combinational from stored refs and test current
    always_comb begin
        res_lim  = BIG_VARIANT ? ECTCS_RES_MAX_BIG : ECTCS_RES_MAX_SML;
        vi_prod  = 21'(test_current_i) * 21'(st_r.res_up);
        v_scaled = 24'(st_r.volt_up) * ECTCS_ORES_SCALE;
        // volt/cur over 0.6 ohm reduces to volt * 1000 above cur * 6000 in these units
        i_scaled = 24'(test_current_i) * ECTCS_ORES_LIM;
        remain   = (st_r.ttime > st_r.elapsed) ? (st_r.ttime - st_r.elapsed) : 14'h0;
        block_start = st_r.warn || st_r.ovolt || st_r.ores || st_r.orate;
    end

    // ======================================================================
    // next state
    always_comb begin
        st_nxt            = st_r;
        st_nxt.ack        = 1'b0;
        st_nxt.reject     = 1'b0;
        st_nxt.mon_valid  = 1'b0;
        st_nxt.step_adv   = 1'b0;

        st_nxt.warn  = lower_judge_on_i &&
                       (st_r.volt_mode ? (st_r.volt_up < volt_lower_i)
                                       : (st_r.res_up < res_lower_i));
        st_nxt.ovolt = !st_r.volt_mode && (vi_prod > ECTCS_OVOLT_LIM);
        st_nxt.ores  = st_r.volt_mode && (v_scaled > i_scaled);
        st_nxt.orate = rating_exceeded_i;

        // blink divider for warning indications
        if (st_r.blink_cnt >= 24'(TICK_CYC * 5 - 1)) begin
            st_nxt.blink_cnt = 24'h0;
            st_nxt.blink     = !st_r.blink;
        end else begin
            st_nxt.blink_cnt = st_r.blink_cnt + 24'h1;
        end

        // test timing, 100 ms ticks
        case (st_r.state)
            ECTCS_ST_TEST: begin
                if (st_r.tick_cnt >= 24'(TICK_CYC - 1)) begin
                    st_nxt.tick_cnt = 24'h0;
                    if (st_r.elapsed != ECTCS_TIME_MAX) begin
                        st_nxt.elapsed = st_r.elapsed + 14'h1;
                    end
                end else begin
                    st_nxt.tick_cnt = st_r.tick_cnt + 24'h1;
                end
                if (power_over_i) begin
                    st_nxt.state = ECTCS_ST_PROT;
                    st_nxt.oload = 1'b1;
                end else if (fail_i || pass_i ||
                             (st_r.timer_on && st_r.elapsed >= st_r.ttime)) begin
                    st_nxt.state = (fail_i || pass_hold_i) ? ECTCS_ST_DONE : ECTCS_ST_IDLE;
                end
            end
            ECTCS_ST_IDLE, ECTCS_ST_DONE, ECTCS_ST_PROT: begin
                st_nxt.tick_cnt = 24'h0;
            end
            default: begin
                st_nxt.state = ECTCS_ST_IDLE;
            end
        endcase

        if (req_valid_i) begin
            st_nxt.ack = 1'b1;
            case (req_i.cmd)
                res_upper_ref_cmd: begin
                    if (req_i.value >= 14'(ECTCS_RES_MIN) && req_i.value <= 14'(res_lim)) begin
                        st_nxt.res_up    = req_i.value[10:0];
                        st_nxt.volt_mode = 1'b0;
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                    st_nxt.reply = 14'(st_r.res_up);
                end
                volt_upper_ref_cmd: begin
                    if (req_i.value >= 14'(ECTCS_VOLT_MIN) &&
                        req_i.value <= 14'(ECTCS_VOLT_MAX)) begin
                        st_nxt.volt_up   = req_i.value[9:0];
                        st_nxt.volt_mode = 1'b1;
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                    st_nxt.reply = 14'(st_r.volt_up);
                end
                ECTCS_CMD_OFFSET: begin
                    st_nxt.offset_on = req_i.flag;
                end
                test_timer_cmd: begin
                    if (time_ok(req_i.value)) begin
                        st_nxt.ttime    = req_i.value;
                        st_nxt.timer_on = req_i.flag;
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                end
                resistance_judge_select: begin
                    st_nxt.volt_mode = !req_i.flag;
                end
                voltage_judge_select: begin
                    st_nxt.volt_mode = req_i.flag;
                end
                begin_test_cmd: begin
                    if (!start_screen(st_r.screen)) begin
                        st_nxt.reject = 1'b1;
                    end else if (prog_running_i && step_at_hold_i) begin
                        st_nxt.step_adv = 1'b1;
                    end else if (block_start || st_r.state != ECTCS_ST_IDLE) begin
                        st_nxt.reject = 1'b1;
                    end else begin
                        st_nxt.state    = ECTCS_ST_TEST;
                        st_nxt.elapsed  = 14'h0;
                        st_nxt.tick_cnt = 24'h0;
                    end
                end
                ECTCS_CMD_STOP: begin
                    st_nxt.state = ECTCS_ST_IDLE;
                    st_nxt.oload = 1'b0;
                end
                ECTCS_CMD_SCREEN: begin
                    if (req_i.value <= 14'(ECTCS_SCR_OFFSET)) begin
                        st_nxt.screen = req_i.value[2:0];
                    end else begin
                        st_nxt.reject = 1'b1;
                    end
                end
                current_reading_query: begin
                    st_nxt.reply = 14'(live ? meas_i.cur : held.cur);
                end
                voltage_reading_query: begin
                    st_nxt.reply = 14'(live ? meas_i.volt : held.volt);
                end
                monitor_query: begin
                    st_nxt.mon.dsr       = 8'h0;
                    st_nxt.mon.dsr[ECTCS_DSR_TEST_BIT]  = live;
                    st_nxt.mon.dsr[ECTCS_DSR_OUTON_BIT] = live;
                    st_nxt.mon.volt_mode = st_r.volt_mode;
                    st_nxt.mon.res       = live ? meas_i.res : held.res;
                    st_nxt.mon.cur       = live ? meas_i.cur : held.cur;
                    st_nxt.mon.volt      = live ? meas_i.volt : held.volt;
                    st_nxt.mon.res_max   = res_max;
                    st_nxt.mon.volt_max  = volt_max;
                    st_nxt.mon.time_v    = st_r.timer_on ? remain : st_r.elapsed;
                    st_nxt.mon_valid     = 1'b1;
                end
                ECTCS_CMD_QUERY_SET: begin
                    st_nxt.reply      = (screen_shown_i > ECTCS_SCR_OFFSET) ?
                                        14'(ECTCS_SCR_OTHER) : 14'(screen_shown_i);
                    st_nxt.reply_flag = st_r.offset_on;
                end
                default: begin
                    st_nxt.reject = 1'b1;
                end
            endcase
        end
        // registered copy so the testing output comes straight from a flop
        st_nxt.testing = (st_nxt.state == ECTCS_ST_TEST);
    end

    // ======================================================================
    // registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r           <= '0;
            st_r.res_up    <= ECTCS_RES_DEF;
            st_r.volt_up   <= ECTCS_VOLT_DEF;
            st_r.ttime     <= ECTCS_TIME_DEF;
            st_r.screen    <= ECTCS_SCR_MAIN;
            st_r.state     <= ECTCS_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    assign ack_o                      = st_r.ack;
    assign reject_o                   = st_r.reject;
    assign reply_o                    = st_r.reply;
    assign reply_flag_o               = st_r.reply_flag;
    assign mon_o                      = st_r.mon;
    assign mon_valid_o                = st_r.mon_valid;
    assign res_upper_o                = st_r.res_up;
    assign volt_upper_o               = st_r.volt_up;
    assign volt_mode_o                = st_r.volt_mode;
    assign offset_on_o                = st_r.offset_on;
    assign test_time_o                = st_r.ttime;
    assign timer_on_o                 = st_r.timer_on;
    assign screen_sel_o               = st_r.screen;
    assign testing_o                  = st_r.testing;
    assign step_advance_o             = st_r.step_adv;
    assign limit_order_warn_o         = st_r.warn;
    assign overvoltage_setting_flag_o = st_r.ovolt;
    assign over_resistance_flag_o     = st_r.ores;
    assign over_rating_flag_o         = st_r.orate;
    assign overload_o                 = st_r.oload;
    assign blink_o                    = st_r.blink;
    assign status_o                   = st_r.mon.dsr;
endmodule

// *** verilog/ectcs_hold.sv ***
// ectcs_hold: captures measurement words while testing, keeps last value after
`timescale 1ns/1ps
module ectcs_hold
    import ectcs_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        live_i,
    input  wire ectcs_meas_t meas_i,
    output ectcs_meas_t      held_o,
    output logic [10:0]      res_max_o,
    output logic [9:0]       volt_max_o
);
    typedef struct packed {
        ectcs_meas_t m;
        logic [10:0] rmax;
        logic [9:0]  vmax;
        logic        live_d;
    } ectcs_hold_st_t;

    ectcs_hold_st_t st_r;
    ectcs_hold_st_t st_nxt;

    // ======================================================================
    // capture; maxima restart on a new test
    always_comb begin
        st_nxt        = st_r;
        st_nxt.live_d = live_i;
        if (live_i) begin
            st_nxt.m = meas_i;
            if (!st_r.live_d) begin
                st_nxt.rmax = meas_i.res;
                st_nxt.vmax = meas_i.volt;
            end else begin
                if (meas_i.res > st_r.rmax) st_nxt.rmax = meas_i.res;
                if (meas_i.volt > st_r.vmax) st_nxt.vmax = meas_i.volt;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign held_o     = st_r.m;
    assign res_max_o  = st_r.rmax;
    assign volt_max_o = st_r.vmax;
endmodule

// *** verilog/ectcs_pkg.sv ***
// ectcs_pkg: shared constants and carrier types of the continuity tester command set
package ectcs_pkg;

    // ======================================================================
    // value encodings (integers in the documented resolution steps)
    // resistance in milliohm, voltage in 10 mV, time in 100 ms, current in 100 mA
    localparam logic [10:0] ECTCS_RES_MIN      = 11'd1;
    localparam logic [10:0] ECTCS_RES_MAX_BIG  = 11'd1200;
    localparam logic [10:0] ECTCS_RES_MAX_SML  = 11'd600;
    localparam logic [10:0] ECTCS_RES_DEF      = 11'd1;
    localparam logic [9:0]  ECTCS_VOLT_MIN     = 10'd1;
    localparam logic [9:0]  ECTCS_VOLT_MAX     = 10'd540;
    localparam logic [9:0]  ECTCS_VOLT_DEF     = 10'd60;
    localparam logic [13:0] ECTCS_TIME_MIN     = 14'd3;
    localparam logic [13:0] ECTCS_TIME_MAX     = 14'd9990;
    localparam logic [13:0] ECTCS_TIME_DEF     = 14'd10;
    localparam logic [13:0] ECTCS_TIME_FINE    = 14'd999;
    localparam logic [13:0] ECTCS_TIME_COARSE  = 14'd10;
    // over-voltage limit 5.4 V: current(0.1 A) * res(mohm) = 1e4 * V
    localparam logic [20:0] ECTCS_OVOLT_LIM    = 21'd54000;
    // over-resistance 0.6 ohm: volt(10 mV)*10000 > 600 * cur(100 mA) * 100
    localparam logic [23:0] ECTCS_ORES_SCALE   = 24'd1000;
    localparam logic [23:0] ECTCS_ORES_LIM     = 24'd6000;
    localparam logic [9:0]  ECTCS_CUR_DEF      = 10'd30;

    // status register bits
    localparam int ECTCS_DSR_TEST_BIT  = 2;
    localparam int ECTCS_DSR_OUTON_BIT = 3;

    // clock 25 MHz, 100 ms timer tick
    localparam int ECTCS_CLK_HZ     = 25000000;
    localparam int ECTCS_TICK_MS    = 100;
    localparam int ECTCS_TICK_CYC   = ECTCS_CLK_HZ / 1000 * ECTCS_TICK_MS;

    // ======================================================================
    // command and screen codes
    typedef enum logic [3:0] {
        ECTCS_CMD_NONE      = 4'h0,
        res_upper_ref_cmd   = 4'h1,
        volt_upper_ref_cmd  = 4'h2,
        ECTCS_CMD_OFFSET    = 4'h3,
        test_timer_cmd      = 4'h4,
        begin_test_cmd      = 4'h5,
        ECTCS_CMD_STOP      = 4'h6,
        ECTCS_CMD_SCREEN    = 4'h7,
        resistance_judge_select = 4'h8,
        voltage_judge_select    = 4'h9,
        current_reading_query   = 4'ha,
        monitor_query           = 4'hb,
        voltage_reading_query   = 4'hc,
        ECTCS_CMD_QUERY_SET     = 4'hd
    } ectcs_cmd_t;

    localparam logic [2:0] ECTCS_SCR_MAIN   = 3'h0;
    localparam logic [2:0] ECTCS_SCR_PROG   = 3'h1;
    localparam logic [2:0] ECTCS_SCR_EDIT   = 3'h2;
    localparam logic [2:0] system_setup_screen = 3'h3;
    localparam logic [2:0] ECTCS_SCR_OFFSET = 3'h4;
    localparam logic [2:0] ECTCS_SCR_OTHER  = 3'h5;

    typedef enum logic [1:0] {
        ECTCS_ST_IDLE = 2'b00,
        ECTCS_ST_TEST = 2'b01,
        ECTCS_ST_DONE = 2'b11,
        ECTCS_ST_PROT = 2'b10
    } ectcs_state_t;

    // ======================================================================
    // carriers
    typedef struct packed {
        ectcs_cmd_t  cmd;
        logic [13:0] value;
        logic        flag;
    } ectcs_req_t;

    typedef struct packed {
        logic [10:0] res;
        logic [9:0]  volt;
        logic [9:0]  cur;
    } ectcs_meas_t;

    typedef struct packed {
        logic [7:0]  dsr;
        logic [10:0] res;
        logic [9:0]  cur;
        logic [10:0] res_max;
        logic [9:0]  volt;
        logic [9:0]  volt_max;
        logic [13:0] time_v;
        logic        volt_mode;
    } ectcs_mon_t;

endpackage
